// File: afcd_core.sv
// Request frame checker, command decoder and negative-acknowledgment builder.
`timescale 1ns/1ps
// Function
// - No ETX by position 15: stay silent
// - Reply length follows the recognised command
// - Missing ENQ: 16-byte NAK, code 74
// - Missing ETX: 8/12-byte short NAK on short frames, 16-byte NAK on R, W, A, E, code 74
// - Unknown command letter: 16-byte NAK, code 75
// - NAK header fields may hold anything
// - Standard frame carries R, W, A, E
// - A writes fast, no completion wait
// - Short frame carries lowercase command set
// - Lowercase data keeps its parameter's format
// - Data is four hex digits, MSB first
// - Negative data is two's complement
// - Hex letters are uppercase only
// - Write acknowledgment data is don't-care
// - Checksum: byte sum after SOH, two digits
// - SOH 01h, ETX 03h, NAK 15h
// - Station is two decimal digits, tens 0-3
// - Broadcast 99 executes without reply
module afcd_core
	import afcd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic [15:0] station_id,
	output logic             cmd_valid,
	output afcd_cmd_s        cmd,
	output logic [7:0]       comm_error_code_monitor,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic [7:0]       tx_data
);

	afcd_state_e state_r;
	logic [3:0]  pos_r;
	logic [7:0]  acc_r;
	logic [15:0] st_r;
	logic [7:0]  letter_r;
	afcd_kind_e  kind_r;
	logic [23:0] fld_r;
	logic [15:0] data_r;
	logic        enq_bad_r;
	logic        digit_bad_r;
	logic [3:0]  etx_pos_r;
	logic [3:0]  bcc_hi_r;
	logic [4:0]  tx_pos_r;
	logic [4:0]  nak_len_r;
	logic [7:0]  nak_code_r;
	logic [7:0]  tx_acc_r;
	logic        push;
	logic        fifo_ready;
	logic [7:0]  nak_byte;

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Uppercase hex digit to nibble; bit 4 flags a legal digit.
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h00;
		if (c >= 8'h30 && c <= AFCD_CH_NINE)
			r = {1'b1, c[3:0]};
		else if (c >= 8'h41 && c <= 8'h46)
			r = {1'b1, c[3:0] + 4'h9};
		return r;
	endfunction

	// Nibble to uppercase ASCII hex digit.
	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		return (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
	endfunction

	// Frame class of a command letter.
	function automatic afcd_kind_e kind_of(input logic [7:0] c);
		afcd_kind_e k;
		k = AFCD_CK_UNKNOWN;
		case (c)
			8'h52, 8'h57, 8'h41, 8'h45: k = AFCD_CK_STD;
			8'h61, 8'h65, 8'h66, 8'h6d: k = AFCD_CK_OPT_SEL;
			8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b: k = AFCD_CK_OPT_POLL;
			default: k = AFCD_CK_UNKNOWN;
		endcase
		return k;
	endfunction

	// Expected ETX position of a frame class.
	function automatic logic [3:0] etx_of(input afcd_kind_e k);
		return (k == AFCD_CK_OPT_SEL) ? AFCD_ETX_OPT_SEL :
		       (k == AFCD_CK_OPT_POLL) ? AFCD_ETX_OPT_POLL : AFCD_ETX_STD;
	endfunction

	// Frame length of a frame class; unknown letters answer in standard form.
	function automatic logic [4:0] len_of(input afcd_kind_e k);
		return (k == AFCD_CK_OPT_SEL) ? AFCD_LEN_OPT_SEL :
		       (k == AFCD_CK_OPT_POLL) ? AFCD_LEN_OPT_POLL : AFCD_LEN_STD;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Verdict on a complete frame, taken when the second checksum digit lands.

	logic [4:0]  bcc_lo;
	logic        csum_ok;
	logic        bcast;
	logic        addr_ok;
	logic        etx_bad;
	logic        fmt_err;
	logic        cmd_err;
	logic        verdict;

	assign bcc_lo  = hex_val(rx_data);
	assign csum_ok = bcc_lo[4] && {bcc_hi_r, bcc_lo[3:0]} == acc_r;
	assign bcast   = st_r == {AFCD_CH_NINE, AFCD_CH_NINE};
	// The broadcast address lies outside the tens range, so it must skip the range test.
	assign addr_ok = bcast || (st_r == station_id
		&& st_r[15:8] >= 8'h30 && st_r[15:8] <= 8'h33
		&& st_r[7:0] >= 8'h30 && st_r[7:0] <= AFCD_CH_NINE);
	assign etx_bad = etx_pos_r != etx_of(kind_r);
	assign cmd_err = !enq_bad_r && kind_r == AFCD_CK_UNKNOWN;
	assign fmt_err = enq_bad_r || (!cmd_err && (etx_bad || digit_bad_r));
	// A frame with a bad checksum or a foreign address is dropped silently.
	assign verdict = state_r == AFCD_ST_BCC2 && rx_valid && csum_ok && addr_ok;

	////////////////////////////////////////////////////////////////////////
	// Sequencer: hunts for SOH, walks the frame, then sends any NAK.

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_r <= AFCD_ST_IDLE;
			pos_r   <= '0;
		end
		else
		begin
			case (state_r)
				AFCD_ST_IDLE:
					if (rx_valid && rx_data == AFCD_CH_SOH)
					begin
						state_r <= AFCD_ST_RECV;
						pos_r   <= AFCD_POS_FIRST;
					end
				AFCD_ST_RECV:
					if (rx_valid)
					begin
						if (rx_data == AFCD_CH_SOH)
							pos_r <= AFCD_POS_FIRST;
						else if (rx_data == AFCD_CH_ETX && pos_r > AFCD_POS_CMD)
							state_r <= AFCD_ST_BCC1;
						else if (pos_r == AFCD_POS_LAST)
							state_r <= AFCD_ST_IDLE;
						else
							pos_r <= pos_r + 4'h1;
					end
				AFCD_ST_BCC1:
					if (rx_valid)
						state_r <= AFCD_ST_BCC2;
				AFCD_ST_BCC2:
					if (rx_valid)
						state_r <= (verdict && (fmt_err || cmd_err) && !bcast) ? AFCD_ST_SEND : AFCD_ST_IDLE;
				AFCD_ST_SEND:
					if (push && tx_pos_r == nak_len_r - 5'h1)
						state_r <= AFCD_ST_IDLE;
				default:
					state_r <= AFCD_ST_IDLE;
			endcase
		end
	end

	// Checksum accumulator: cleared at SOH, summed through ETX inclusive.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			acc_r <= '0;
		else if (rx_valid && rx_data == AFCD_CH_SOH && (state_r == AFCD_ST_IDLE || state_r == AFCD_ST_RECV))
			acc_r <= '0;
		else if (rx_valid && state_r == AFCD_ST_RECV)
			acc_r <= acc_r + rx_data;
	end

	// Field capture and format checks while the frame streams in.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_r        <= '0;
			letter_r    <= '0;
			kind_r      <= AFCD_CK_UNKNOWN;
			fld_r       <= '0;
			data_r      <= '0;
			enq_bad_r   <= 1'b0;
			digit_bad_r <= 1'b0;
			etx_pos_r   <= '0;
			bcc_hi_r    <= '0;
		end
		else if (rx_valid && state_r == AFCD_ST_IDLE)
		begin
			enq_bad_r   <= 1'b0;
			digit_bad_r <= 1'b0;
		end
		else if (rx_valid && state_r == AFCD_ST_RECV)
		begin
			if (rx_data == AFCD_CH_SOH)
			begin
				enq_bad_r   <= 1'b0;
				digit_bad_r <= 1'b0;
			end
			else if (rx_data == AFCD_CH_ETX && pos_r > AFCD_POS_CMD)
				etx_pos_r <= pos_r;
			else if (pos_r < AFCD_POS_ENQ)
				st_r <= {st_r[7:0], rx_data};
			else if (pos_r == AFCD_POS_ENQ)
				enq_bad_r <= rx_data != AFCD_CH_ENQ;
			else if (pos_r == AFCD_POS_CMD)
			begin
				letter_r <= rx_data;
				kind_r   <= kind_of(rx_data);
			end
			else if (kind_r == AFCD_CK_STD && pos_r < AFCD_POS_CMD + 4'h4)
				fld_r <= {fld_r[15:0], rx_data};
			// Data digits shift in MSB first; the word is kept as raw bits so
			// signed values stay in two's complement and each lowercase letter
			// keeps the numeric format of the parameter it stands for.
			else if (pos_r >= ((kind_r == AFCD_CK_STD) ? AFCD_DATA_STD : AFCD_DATA_OPT)
				&& pos_r < ((kind_r == AFCD_CK_STD) ? AFCD_ETX_STD : AFCD_ETX_OPT_SEL))
			begin
				data_r <= {data_r[11:0], hex_val(rx_data)[3:0]};
				if (!hex_val(rx_data)[4])
					digit_bad_r <= 1'b1;
			end
		end
		else if (rx_valid && state_r == AFCD_ST_BCC1)
			bcc_hi_r <= hex_val(rx_data)[3:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Command hand-off and error-code latch.

	// Good frames pulse cmd_valid; broadcasts execute too, they only lose the reply.
	// The positive reply is left to the execution side, whose write data may be anything.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cmd_valid <= 1'b0;
			cmd       <= '0;
		end
		else
		begin
			cmd_valid <= verdict && !fmt_err && !cmd_err;
			if (verdict && !fmt_err && !cmd_err)
			begin
				cmd.letter      <= letter_r;
				cmd.kind        <= kind_r;
				cmd.reply_len   <= len_of(kind_r);
				cmd.fields      <= fld_r;
				cmd.data        <= data_r;
				cmd.fast_write  <= letter_r == 8'h41;
				cmd.alarm_reset <= letter_r == 8'h45 || letter_r == 8'h6d;
				cmd.broadcast   <= bcast;
			end
		end
	end

	// Holds the newest error so a later monitor read returns it.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			comm_error_code_monitor <= AFCD_ERR_RESET;
		else if (verdict && (fmt_err || cmd_err))
			comm_error_code_monitor <= cmd_err ? AFCD_ERR_COMMAND : AFCD_ERR_FORMAT;
	end

	////////////////////////////////////////////////////////////////////////
	// NAK builder; the FIFO's ready stalls it byte by byte.

	// ENQ and unknown-letter errors use the 16-byte form; ETX errors on short
	// commands use the short form of their class.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			nak_len_r  <= AFCD_LEN_STD;
			nak_code_r <= AFCD_ERR_RESET;
		end
		else if (verdict)
		begin
			nak_len_r  <= (enq_bad_r || cmd_err) ? AFCD_LEN_STD : len_of(kind_r);
			nak_code_r <= cmd_err ? AFCD_ERR_COMMAND : AFCD_ERR_FORMAT;
		end
	end

	// Header fields of the long form echo those of the last standard-letter frame, since they carry no meaning.
	always_comb
	begin
		nak_byte = AFCD_CH_SP;
		if (tx_pos_r == 5'h0)
			nak_byte = AFCD_CH_SOH;
		else if (tx_pos_r == 5'h1)
			nak_byte = st_r[15:8];
		else if (tx_pos_r == 5'h2)
			nak_byte = st_r[7:0];
		else if (tx_pos_r == 5'h3)
			nak_byte = AFCD_CH_NAK;
		else if (tx_pos_r == 5'h4)
			nak_byte = letter_r;
		else if (tx_pos_r == nak_len_r - 5'h3)
			nak_byte = AFCD_CH_ETX;
		else if (tx_pos_r == nak_len_r - 5'h2)
			nak_byte = hex_chr(tx_acc_r[7:4]);
		else if (tx_pos_r == nak_len_r - 5'h1)
			nak_byte = hex_chr(tx_acc_r[3:0]);
		else if (tx_pos_r == nak_len_r - 5'h5)
			nak_byte = hex_chr(nak_code_r[7:4]);
		else if (tx_pos_r == nak_len_r - 5'h4)
			nak_byte = hex_chr(nak_code_r[3:0]);
		else if (nak_len_r == AFCD_LEN_STD && tx_pos_r < 5'h8)
			nak_byte = fld_r[8'(23 - 8 * (tx_pos_r - 5'h5)) -: 8];
	end

	assign push = state_r == AFCD_ST_SEND && fifo_ready;

	// Byte index and running checksum of the outgoing frame.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || state_r != AFCD_ST_SEND)
		begin
			tx_pos_r <= '0;
			tx_acc_r <= '0;
		end
		else if (push)
		begin
			tx_pos_r <= tx_pos_r + 5'h1;
			if (tx_pos_r != 5'h0 && tx_pos_r < nak_len_r - 5'h2)
				tx_acc_r <= tx_acc_r + nak_byte;
		end
	end

	afcd_fifo #(
		.WIDTH (AFCD_FIFO_WIDTH),
		.DEPTH (AFCD_FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (state_r == AFCD_ST_SEND),
		.in_ready  (fifo_ready),
		.in_data   (nak_byte),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_etx_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == AFCD_ST_RECV && rx_valid && pos_r == AFCD_POS_LAST && rx_data != AFCD_CH_ETX
		&& rx_data != AFCD_CH_SOH |=> state_r == AFCD_ST_IDLE)
		else $error("frame without ETX was not abandoned");
	a_reply_len: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_valid |-> cmd.reply_len == len_of(cmd.kind))
		else $error("reply length does not match command class");
	a_enq_nak: assert property (@(posedge core_clk) disable iff (!rst_n)
		verdict && enq_bad_r |=> nak_len_r == AFCD_LEN_STD && nak_code_r == AFCD_ERR_FORMAT)
		else $error("ENQ error did not give long format NAK");
	a_etx_nak: assert property (@(posedge core_clk) disable iff (!rst_n)
		verdict && !enq_bad_r && !cmd_err && etx_bad && kind_r == AFCD_CK_OPT_SEL
		|=> nak_len_r == AFCD_LEN_OPT_SEL && comm_error_code_monitor == AFCD_ERR_FORMAT)
		else $error("ETX error on selecting did not give short NAK");
	a_cmd_nak: assert property (@(posedge core_clk) disable iff (!rst_n)
		verdict && cmd_err |=> nak_code_r == AFCD_ERR_COMMAND && !cmd_valid)
		else $error("unknown command not rejected with code 75");
	a_bcast_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == AFCD_ST_BCC2 && rx_valid && bcast |=> state_r == AFCD_ST_IDLE)
		else $error("broadcast frame produced a reply");
	a_nak_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
		push && tx_pos_r == 5'h3 |-> nak_byte == AFCD_CH_NAK ##1 tx_pos_r == 5'h4)
		else $error("NAK character misplaced");
	a_tx_csum: assert property (@(posedge core_clk) disable iff (!rst_n)
		push && tx_pos_r == nak_len_r - 5'h1 |-> nak_byte == hex_chr(tx_acc_r[3:0])
		##1 state_r == AFCD_ST_IDLE)
		else $error("NAK checksum or frame end wrong");
	a_acc_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == AFCD_ST_IDLE && rx_valid && rx_data == AFCD_CH_SOH |=> acc_r == 8'h00)
		else $error("checksum accumulator not cleared at SOH");
	a_err_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
		verdict && fmt_err && !cmd_err |=> comm_error_code_monitor == AFCD_ERR_FORMAT)
		else $error("format error code not latched");

endmodule // afcd_core

// File: afcd_fifo.sv
// Shift-register FIFO whose head entry and flags are all flip-flops.
`timescale 1ns/1ps
module afcd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;
	assign out_data = mem_r[0];

	// Occupancy; ready and valid are registered so they never glitch on the ports.
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = cnt_r + CW'(1);
		else if (pop && !push)
			cnt_nxt = cnt_r - CW'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cnt_r     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			cnt_r     <= cnt_nxt;
			in_ready  <= cnt_nxt != CW'(DEPTH);
			out_valid <= cnt_nxt != '0;
		end
	end

	// Each slot shifts toward the head on a pop and takes new data at the tail.
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_slot
			always_ff @(posedge core_clk)
			begin
				if (push && CW'(gi) == (pop ? cnt_r - CW'(1) : cnt_r))
					mem_r[gi] <= in_data;
				else if (pop && gi < DEPTH - 1)
					mem_r[gi] <= mem_r[(gi < DEPTH - 1) ? gi + 1 : gi];
			end
		end
	endgenerate

endmodule // afcd_fifo

// File: afcd_host.sv
// Behavioural host model: feeds request bytes in and collects reply bytes.
`timescale 1ns/1ps
module afcd_host
	import afcd_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic       slow = 1'b0;
	logic [7:0] last = 8'h00;

	initial
	begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One byte per cycle, with random gaps when slow; an idle line shows the inverse of the last byte.
	always @(posedge core_clk)
	begin
		if (rst_n && txq.size() != 0 && !(slow && $urandom_range(1, 0) == 0))
		begin
			rx_valid <= 1'b1;
			last = txq.pop_front();
			rx_data  <= last;
		end
		else
		begin
			rx_valid <= 1'b0;
			rx_data  <= ~last;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reply bytes are taken on valid and ready; a slow host stalls often so the buffer fills.
	always @(posedge core_clk)
	begin
		if (tx_valid === 1'b1 && tx_ready)
			rxq.push_back(tx_data);
		tx_ready <= slow ? 1'($urandom_range(3, 0) == 0) : 1'b1;
	end
endmodule // afcd_host

// File: afcd_pkg.sv
// Constants, encodings and carrier types for the ASCII frame checker and decoder.
package afcd_pkg;

	// Control and other fixed characters of the framing.
	localparam logic [7:0] AFCD_CH_SOH  = 8'h01;
	localparam logic [7:0] AFCD_CH_ETX  = 8'h03;
	localparam logic [7:0] AFCD_CH_ENQ  = 8'h05;
	localparam logic [7:0] AFCD_CH_NAK  = 8'h15;
	localparam logic [7:0] AFCD_CH_SP   = 8'h20;
	localparam logic [7:0] AFCD_CH_NINE = 8'h39;

	// Communication error codes, as the monitor reports them (74 and 75 decimal).
	localparam logic [7:0] AFCD_ERR_FORMAT  = 8'h4a;
	localparam logic [7:0] AFCD_ERR_COMMAND = 8'h4b;
	localparam logic [7:0] AFCD_ERR_RESET   = 8'h00;

	// Byte positions inside a request frame.
	localparam logic [3:0] AFCD_POS_FIRST    = 4'h1;
	localparam logic [3:0] AFCD_POS_ENQ      = 4'h3;
	localparam logic [3:0] AFCD_POS_CMD      = 4'h4;
	localparam logic [3:0] AFCD_POS_LAST     = 4'hf;
	localparam logic [3:0] AFCD_ETX_STD      = 4'hd;
	localparam logic [3:0] AFCD_ETX_OPT_SEL  = 4'h9;
	localparam logic [3:0] AFCD_ETX_OPT_POLL = 4'h5;
	localparam logic [3:0] AFCD_DATA_STD     = 4'h9;
	localparam logic [3:0] AFCD_DATA_OPT     = 4'h5;

	// Frame lengths in bytes.
	localparam logic [4:0] AFCD_LEN_STD      = 5'h10;
	localparam logic [4:0] AFCD_LEN_OPT_SEL  = 5'h08;
	localparam logic [4:0] AFCD_LEN_OPT_POLL = 5'h0c;

	// Transmit buffer shape.
	localparam int AFCD_FIFO_WIDTH = 8;
	localparam int AFCD_FIFO_DEPTH = 8;

	// Receive and reply sequencer states.
	typedef enum logic [4:0] {
		AFCD_ST_IDLE = 5'b00001,
		AFCD_ST_RECV = 5'b00010,
		AFCD_ST_BCC1 = 5'b00100,
		AFCD_ST_BCC2 = 5'b01000,
		AFCD_ST_SEND = 5'b10000
	} afcd_state_e;

	// Frame class that a command letter belongs to.
	typedef enum logic [1:0] {
		AFCD_CK_UNKNOWN  = 2'h0,
		AFCD_CK_STD      = 2'h1,
		AFCD_CK_OPT_SEL  = 2'h2,
		AFCD_CK_OPT_POLL = 2'h3
	} afcd_kind_e;

	// Decoded command handed to the execution logic.
	typedef struct packed {
		logic [7:0]  letter;
		afcd_kind_e  kind;
		logic [4:0]  reply_len;
		logic [23:0] fields;
		logic [15:0] data;
		logic        fast_write;
		logic        alarm_reset;
		logic        broadcast;
	} afcd_cmd_s;

endpackage

// File: test_ascii_frame_checker_decoder.sv
// Self-checking bench for the frame checker: good frames, every error reply and the silent cases.
`timescale 1ns/1ps
module test_ascii_frame_checker_decoder
	import afcd_pkg::*;
();
	typedef logic [7:0] afcd_bq_t[$];
	logic        core_clk   = 1'b0;
	logic        rst_n      = 1'b0;
	logic [15:0] station_id = 16'h3132;
	logic        rx_valid;
	logic        tx_valid;
	logic        tx_ready;
	logic        cmd_valid;
	logic [7:0]  rx_data;
	logic [7:0]  tx_data;
	logic [7:0]  comm_error_code_monitor;
	afcd_cmd_s   cmd;
	afcd_cmd_s   cmd_q;
	int          mismatches = 0;
	int          tests_run  = 0;
	int          cmd_cnt    = 0;
	logic [7:0]  st1;
	logic [7:0]  st0;
	string       cmds = "RWAEaefmghijk";

	afcd_core afcd_core_inst (.core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.station_id(station_id), .cmd_valid(cmd_valid), .cmd(cmd),
		.comm_error_code_monitor(comm_error_code_monitor), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data));
	afcd_host afcd_host_inst (.core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	// Free-running 10 MHz clock.
	always #50 core_clk = ~core_clk;

	// Counts decoded pulses and keeps the command they carried.
	always @(posedge core_clk)
	begin
		if (cmd_valid === 1'b1)
		begin
			cmd_cnt++;
			cmd_q = cmd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hex digit in ASCII, letters always upper case.
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction

	// Byte sum after the start byte through index last, low byte kept.
	function automatic logic [7:0] bsum(input afcd_bq_t q, input int last);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 1; i <= last; i++)
			s += q[i];
		return s;
	endfunction

	// Frame class of a letter: 0 standard, 1 short selecting, 2 short polling.
	function automatic int shape_of(input logic [7:0] c);
		if (c inside {8'h52, 8'h57, 8'h41, 8'h45})
			return 0;
		if (c inside {8'h61, 8'h65, 8'h66, 8'h6d})
			return 1;
		return 2;
	endfunction

	// Request up to its end byte; the checksum is added when sent.
	function automatic afcd_bq_t frame(input logic [7:0] c, input logic [15:0] d, input int sh);
		afcd_bq_t q;
		q = {AFCD_CH_SOH, st1, st0, AFCD_CH_ENQ, c};
		if (sh == 0)
			q = {q, 8'h53, 8'h30, 8'h31, AFCD_CH_SP};
		if (sh != 2)
			q = {q, hx(d[15:12]), hx(d[11:8]), hx(d[7:4]), hx(d[3:0])};
		q.push_back(AFCD_CH_ETX);
		return q;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Seals a request with its checksum (skewed to corrupt it) and waits until the host has sent it.
	task automatic send(input afcd_bq_t q, input logic [7:0] skew);
		logic [7:0] s;
		s = bsum(q, q.size() - 1) + skew;
		q = {q, hx(s[7:4]), hx(s[3:0])};
		afcd_host_inst.txq = {afcd_host_inst.txq, q};
		for (int i = 0; i < 500 && afcd_host_inst.txq.size() != 0; i++)
			cyc(1);
		if (afcd_host_inst.txq.size() != 0)
		begin
			chk(1'b0, "request never sent");
			stop_test();
		end
		cyc(5);
	endtask

	// A good request must decode once and draw no reply from this block.
	task automatic good(input logic [7:0] c, input logic [15:0] d, input logic bc);
		int         n;
		int         r;
		int         sh;
		logic [7:0] m;
		n = cmd_cnt;
		r = afcd_host_inst.rxq.size();
		sh = shape_of(c);
		m = comm_error_code_monitor;
		send(frame(c, d, sh), 8'h00);
		chk(cmd_cnt === n + 1, "good frame not decoded");
		chk(cmd_q.letter === c, "letter");
		chk(cmd_q.kind === (sh == 0 ? AFCD_CK_STD : sh == 1 ? AFCD_CK_OPT_SEL : AFCD_CK_OPT_POLL), "kind");
		chk(cmd_q.reply_len === (sh == 0 ? AFCD_LEN_STD : sh == 1 ? AFCD_LEN_OPT_SEL : AFCD_LEN_OPT_POLL), "len");
		if (sh != 2)
			chk(cmd_q.data === d, "data value");
		if (sh == 0)
			chk(cmd_q.fields === 24'h533031, "fields");
		chk(cmd_q.fast_write === (c == 8'h41), "fast write");
		chk(cmd_q.alarm_reset === (c == 8'h45 || c == 8'h6d), "alarm reset");
		chk(cmd_q.broadcast === bc, "broadcast flag");
		cyc(20);
		chk(afcd_host_inst.rxq.size() === r && comm_error_code_monitor === m, "stray reply");
	endtask

	// A faulty request must draw exactly one negative reply of the given length and code.
	task automatic bad(input afcd_bq_t q, input int len, input logic [7:0] code);
		int         n;
		int         r;
		logic [7:0] s;
		afcd_bq_t   t;
		n = cmd_cnt;
		r = afcd_host_inst.rxq.size();
		send(q, 8'h00);
		for (int i = 0; i < 800 && afcd_host_inst.rxq.size() < r + len; i++)
			cyc(1);
		if (afcd_host_inst.rxq.size() < r + len)
		begin
			chk(1'b0, "reply missing");
			stop_test();
		end
		cyc(20);
		t = afcd_host_inst.rxq[r:$];
		chk(t.size() === len, "reply length");
		chk(t[0] === AFCD_CH_SOH && t[3] === AFCD_CH_NAK && t[len-3] === AFCD_CH_ETX, "framing");
		chk(t[1] === st1 && t[2] === st0, "station");
		s = bsum(t, len - 3);
		chk(t[len-2] === hx(s[7:4]) && t[len-1] === hx(s[3:0]), "checksum");
		if (len != 8)
			chk(t[len-5] === hx(code[7:4]) && t[len-4] === hx(code[3:0]), "code digits");
		if (len != 8)
			chk(t[len-6] === AFCD_CH_SP && t[len-7] === AFCD_CH_SP, "spaces");
		chk(comm_error_code_monitor === code && cmd_cnt === n, "error latch");
	endtask

	// A request that must be dropped without any reply or state change.
	task automatic silent(input afcd_bq_t q, input logic [7:0] skew);
		int         n;
		int         r;
		logic [7:0] m;
		n = cmd_cnt;
		r = afcd_host_inst.rxq.size();
		m = comm_error_code_monitor;
		send(q, skew);
		cyc(20);
		chk(afcd_host_inst.rxq.size() === r && cmd_cnt === n && comm_error_code_monitor === m, "answered");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: every letter good, then each error class, then the silent and broadcast cases.
	initial
	begin
		afcd_bq_t    q;
		logic [15:0] d;
		void'($urandom(71623));
		st1 = 8'h30 + 8'($urandom_range(3, 0));
		st0 = 8'h30 + 8'($urandom_range(9, 0));
		cyc(16);
		station_id <= {st1, st0};
		rst_n <= 1'b1;
		cyc(2);
		chk(comm_error_code_monitor === AFCD_ERR_RESET && tx_valid === 1'b0, "reset state");
		for (int i = 0; i < 13; i++)
		begin
			d = (i == 0) ? 16'h0000 : (i == 1) ? 16'he5f5 : (i == 2) ? 16'hffff : 16'($urandom);
			good(cmds[i], d, 1'b0);
		end
		// The slow host stalls replies so the buffer fills while bytes trickle in.
		afcd_host_inst.slow = 1'b1;
		q = frame(8'h57, 16'h1a0b, 0);
		q[3] = 8'h06;
		bad(q, 16, AFCD_ERR_FORMAT);
		q = frame(8'h66, 16'h0001, 1);
		q[3] = 8'h06;
		bad(q, 16, AFCD_ERR_FORMAT);
		bad(frame(8'h5a, 16'h0000, 0), 16, AFCD_ERR_COMMAND);
		for (int i = 4; i < 13; i++)
		begin
			q = frame(cmds[i], 16'($urandom), shape_of(cmds[i]));
			q.insert(q.size() - 1, 8'h30);
			bad(q, shape_of(cmds[i]) == 1 ? 8 : 12, AFCD_ERR_FORMAT);
		end
		bad(frame(8'h62, 16'h0000, 0), 16, AFCD_ERR_COMMAND);
		q = frame(8'h57, 16'h00ab, 0);
		q[11] = 8'h61;
		bad(q, 16, AFCD_ERR_FORMAT);
		q = frame(8'h52, 16'h0000, 0);
		q[13] = 8'h30;
		silent(q, 8'h00);
		silent(frame(8'h57, 16'h1234, 0), 8'h01);
		// Own address given the same illegal tens digit, so only the range test can drop the frame.
		d = station_id;
		st1 = 8'h34;
		station_id <= {st1, st0};
		silent(frame(8'h57, 16'h1234, 0), 8'h00);
		station_id <= d;
		st1 = 8'h39;
		st0 = 8'h39;
		good(8'h66, 16'h0002, 1'b1);
		st1 = station_id[15:8];
		st0 = station_id[7:0];
		good(8'h41, 16'h8000, 1'b0);
		stop_test();
	end
endmodule // test_ascii_frame_checker_decoder
